// ---- logic/gyro_regs_defs.svh ----
`ifndef GYRO_REGS_DEFS_SVH
`define GYRO_REGS_DEFS_SVH

// Register offsets
`define ADDR_INT_FLAGS       8'h3A
`define ADDR_TEMP_HIGH       8'h41
`define ADDR_TEMP_LOW        8'h42
`define ADDR_RATE_X_HIGH     8'h43
`define ADDR_RATE_X_LOW      8'h44
`define ADDR_RATE_Y_HIGH     8'h45
`define ADDR_RATE_Y_LOW      8'h46
`define ADDR_RATE_Z_HIGH     8'h47
`define ADDR_RATE_Z_LOW      8'h48
`define ADDR_PATH_RESET      8'h68
`define ADDR_USER_CONTROL    8'h6A

// Field positions
`define BIT_OVERFLOW         4
`define BIT_DRIVE_READY      2
`define BIT_DATA_READY       0
`define BIT_TEMP_PATH_RST    0
`define BIT_FIFO_ENABLE      6
`define BIT_SPI_LOCK         4
`define BIT_FIFO_RST         2
`define BIT_SENSING_RST      0
`define BIT_IRQ_EN_OVERFLOW  4

// Reset values
`define RST_FLAGS            8'h00
`define RST_BYTE             8'h00
`define RST_RESULT           16'h0000

// Timing
`define CLK_PERIOD_NS        50
`define SELF_CLEAR_NS        50
`define SELF_CLEAR_CYCLES    ((`SELF_CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- logic/gyro_regs_pkg.sv ----
package gyro_regs_pkg;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] rdata;
  } reg_rsp_t;

  // Channel 0 temperature, 1..3 rate X, Y, Z
  typedef struct packed {
    logic             valid;
    logic [3:0][15:0] value;
  } sample_t;

  typedef struct packed {
    logic temp_path_rst;
    logic rate_path_rst;
    logic fifo_rst;
    logic i2c_rst;
    logic spi_only;
    logic fifo_enable;
  } path_ctrl_t;

  typedef enum logic [1:0] {
    CH_TEMP   = 2'h0,
    CH_RATE_X = 2'h1,
    CH_RATE_Y = 2'h2,
    CH_RATE_Z = 2'h3
  } chan_t;

endpackage : gyro_regs_pkg

// ---- logic/gyro_status_output_control_regs.sv ----
// How it works
// - Overflow sets bit 4, status read clears
// - Data-ready sets bit 0, status read clears
// - Drive-ready event shown in bit 2
// - Temperature high at 0x41, low 0x42
// - Rate X high at 0x43, low 0x44
// - Rate Y high at 0x45, low 0x46
// - Rate Z high at 0x47, low 0x48
// - Rate output is sensitivity times rate
// - Path-reset bit 0 resets temperature path only
// - User-control bit 6 enables FIFO access
// - Bit 4 resets I2C, locks SPI, self-clears
// - Bit 2 resets FIFO, self-clears
// - Bit 0 resets paths, clears all results
// - Overflow drives interrupt only when enabled
// - Read-clear config lets any read clear
`timescale 1ns/1ps
`include "gyro_regs_defs.svh"

module gyro_status_output_control_regs #(
  parameter int unsigned PULSE_CYCLES = `SELF_CLEAR_CYCLES
) (
  input  wire logic                       i_clk,             // 20 MHz internal clock
  input  wire logic                       i_rst,             // Async reset, high
  input  wire gyro_regs_pkg::reg_req_t    i_req,             // Serial front-end access
  input  wire logic                       i_burst_active,    // Serial transaction open
  input  wire gyro_regs_pkg::sample_t     i_sample,          // New results, valid pulse
  input  wire logic                       i_overflow_event,  // FIFO overflow pulse
  input  wire logic                       i_drive_ready_event, // Drive ready pulse
  input  wire logic                       i_read_clear_any,  // Any read clears flags
  input  wire logic [7:0]                 i_irq_enable,      // Interrupt enable byte
  output gyro_regs_pkg::reg_rsp_t         o_rsp,             // Read answer, one cycle
  output gyro_regs_pkg::path_ctrl_t       o_ctrl,            // Path resets and modes
  output logic                            o_irq              // Interrupt request, high
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  localparam logic [7:0] FLAG_MASK = 8'((1 << `BIT_OVERFLOW) |
                                        (1 << `BIT_DRIVE_READY) |
                                        (1 << `BIT_DATA_READY));
  localparam int unsigned CNT_W = (PULSE_CYCLES > 1) ? $clog2(PULSE_CYCLES) : 1;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Maps a result byte address to its channel; high byte at odd offsets
  function automatic logic [3:0] result_slot(input logic [7:0] addr);
    logic [3:0] s;
    s = 4'h0;
    unique case (addr)
      `ADDR_TEMP_HIGH:   s = {1'b1, gyro_regs_pkg::CH_TEMP,   1'b1};
      `ADDR_TEMP_LOW:    s = {1'b1, gyro_regs_pkg::CH_TEMP,   1'b0};
      `ADDR_RATE_X_HIGH: s = {1'b1, gyro_regs_pkg::CH_RATE_X, 1'b1};
      `ADDR_RATE_X_LOW:  s = {1'b1, gyro_regs_pkg::CH_RATE_X, 1'b0};
      `ADDR_RATE_Y_HIGH: s = {1'b1, gyro_regs_pkg::CH_RATE_Y, 1'b1};
      `ADDR_RATE_Y_LOW:  s = {1'b1, gyro_regs_pkg::CH_RATE_Y, 1'b0};
      `ADDR_RATE_Z_HIGH: s = {1'b1, gyro_regs_pkg::CH_RATE_Z, 1'b1};
      `ADDR_RATE_Z_LOW:  s = {1'b1, gyro_regs_pkg::CH_RATE_Z, 1'b0};
      default:           s = 4'h0;
    endcase
    result_slot = s;
  endfunction : result_slot

  logic rd_strobe;
  logic wr_strobe;
  logic wr_path;
  logic wr_user;
  logic sensing_clear;

  assign rd_strobe     = i_req.valid & ~i_req.write;
  assign wr_strobe     = i_req.valid & i_req.write;
  assign wr_path       = wr_strobe & hit(i_req.addr, `ADDR_PATH_RESET);
  assign wr_user       = wr_strobe & hit(i_req.addr, `ADDR_USER_CONTROL);
  assign sensing_clear = wr_user & i_req.wdata[`BIT_SENSING_RST];

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  // Three live flags; reserved bits are never stored
  logic       flag_q [3];  // 2 overflow, 1 drive ready, 0 data ready
  logic [2:0] flag_evt;
  logic       flag_clr;
  logic [7:0] flags_view;
  logic [7:0] irq_src;

  // Shared by the read mux and the interrupt output
  function automatic logic [7:0] place_flags(input logic [2:0] b);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_OVERFLOW]    = b[2];
    v[`BIT_DRIVE_READY] = b[1];
    v[`BIT_DATA_READY]  = b[0];
    place_flags = v;
  endfunction : place_flags

  assign flag_evt[2] = i_overflow_event;
  assign flag_evt[1] = i_drive_ready_event;
  assign flag_evt[0] = i_sample.valid;
  assign flags_view  = place_flags({flag_q[2], flag_q[1], flag_q[0]}) & FLAG_MASK;

  // Any read clears when the read-clear option is on
  assign flag_clr = rd_strobe & (hit(i_req.addr, `ADDR_INT_FLAGS) | i_read_clear_any);

  // Set wins over a clear in the same edge, so an event is never lost to a read
  genvar fl;
  generate
    for (fl = 0; fl < 3; fl++) begin : g_flag
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          flag_q[fl] <= 1'b0;
        end else if (flag_evt[fl]) begin
          flag_q[fl] <= 1'b1;
        end else if (flag_clr) begin
          flag_q[fl] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_src = flags_view & i_irq_enable & FLAG_MASK;

  // Every flag source is gated here by its own bit of i_irq_enable; the request is registered
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |irq_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result storage

  logic [15:0] live_q   [4];
  logic [15:0] shadow_q [4];

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      // Results arrive already scaled by the sensitivity of the chosen range
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          live_q[ch] <= `RST_RESULT;
        end else if (sensing_clear) begin
          live_q[ch] <= `RST_RESULT;
        end else if (i_sample.valid) begin
          live_q[ch] <= i_sample.value[ch];
        end
      end

      // Frozen while a transaction is open so high and low bytes pair up
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          shadow_q[ch] <= `RST_RESULT;
        end else if (sensing_clear) begin
          shadow_q[ch] <= `RST_RESULT;
        end else if (!i_burst_active) begin
          shadow_q[ch] <= live_q[ch];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Control bits

  logic             fifo_enable_q;
  logic             spi_only_q;
  logic             i2c_pulse_q;
  logic             fifo_pulse_q;
  logic             sense_pulse_q;
  logic             temp_pulse_q;
  logic             temp_any_q;
  logic [CNT_W-1:0] pulse_cnt_q;
  logic             pulse_live;
  logic             pulse_start;
  logic             pulse_end;
  logic             user_i2c_bit;
  logic             user_fifo_bit;
  logic             user_sense_bit;
  logic             path_temp_bit;

  gyro_regs_pkg::path_ctrl_t pulse_req;

  assign pulse_live     = (pulse_cnt_q != '0);
  assign pulse_start    = wr_user | wr_path;
  assign pulse_end      = ~pulse_start & ~pulse_live;
  assign user_i2c_bit   = wr_user & i_req.wdata[`BIT_SPI_LOCK];
  assign user_fifo_bit  = wr_user & i_req.wdata[`BIT_FIFO_RST];
  assign user_sense_bit = sensing_clear;
  assign path_temp_bit  = wr_path & i_req.wdata[`BIT_TEMP_PATH_RST];

  // Pulse requests carried by the current write, one field per reset line
  always_comb begin
    pulse_req               = '0;
    pulse_req.temp_path_rst = path_temp_bit | user_sense_bit;
    pulse_req.rate_path_rst = user_sense_bit;
    pulse_req.fifo_rst      = user_fifo_bit;
    pulse_req.i2c_rst       = user_i2c_bit;
    pulse_req.spi_only      = 1'b0;
    pulse_req.fifo_enable   = 1'b0;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fifo_enable_q <= 1'b0;
    end else if (wr_user) begin
      fifo_enable_q <= i_req.wdata[`BIT_FIFO_ENABLE];
    end
  end

  // Lock holds until device reset; the I2C reset itself is a pulse
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      spi_only_q <= 1'b0;
    end else if (wr_user && i_req.wdata[`BIT_SPI_LOCK]) begin
      spi_only_q <= 1'b1;
    end
  end

  // One timer serves every pulse; a fresh write restarts it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_cnt_q <= '0;
    end else if (pulse_start) begin
      pulse_cnt_q <= CNT_W'(PULSE_CYCLES - 1);
    end else if (pulse_live) begin
      pulse_cnt_q <= pulse_cnt_q - CNT_W'(1);
    end
  end

  // Any new control write ends the pulses it does not name
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      i2c_pulse_q <= 1'b0;
    end else if (pulse_start) begin
      i2c_pulse_q <= pulse_req.i2c_rst;
    end else if (pulse_end) begin
      i2c_pulse_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fifo_pulse_q <= 1'b0;
    end else if (pulse_start) begin
      fifo_pulse_q <= pulse_req.fifo_rst;
    end else if (pulse_end) begin
      fifo_pulse_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sense_pulse_q <= 1'b0;
    end else if (pulse_start) begin
      sense_pulse_q <= pulse_req.rate_path_rst;
    end else if (pulse_end) begin
      sense_pulse_q <= 1'b0;
    end
  end

  // Path-reset readback only; the full sensing reset does not show here
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_pulse_q <= 1'b0;
    end else if (pulse_start) begin
      temp_pulse_q <= path_temp_bit;
    end else if (pulse_end) begin
      temp_pulse_q <= 1'b0;
    end
  end

  // Temperature path also resets with the full sensing reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_any_q <= 1'b0;
    end else if (pulse_start) begin
      temp_any_q <= pulse_req.temp_path_rst;
    end else if (pulse_end) begin
      temp_any_q <= 1'b0;
    end
  end

  // Every field is a flop copy, nothing is decoded on the way out
  always_comb begin
    o_ctrl               = '0;
    o_ctrl.temp_path_rst = temp_any_q;
    o_ctrl.rate_path_rst = sense_pulse_q;
    o_ctrl.fifo_rst      = fifo_pulse_q;
    o_ctrl.i2c_rst       = i2c_pulse_q;
    o_ctrl.spi_only      = spi_only_q;
    o_ctrl.fifo_enable   = fifo_enable_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path

  // Readback of the user control byte; reserved bits stay zero
  function automatic logic [7:0] user_view(input logic fen, input logic i2c,
                                           input logic fifo, input logic sense);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_FIFO_ENABLE] = fen;
    v[`BIT_SPI_LOCK]    = i2c;
    v[`BIT_FIFO_RST]    = fifo;
    v[`BIT_SENSING_RST] = sense;
    user_view = v;
  endfunction : user_view

  logic [7:0]  rd_mux;
  logic [3:0]  slot;
  logic [15:0] word;

  // Result bytes come from the shadow, so a pair read in one burst matches
  always_comb begin
    rd_mux = 8'h00;
    slot   = result_slot(i_req.addr);
    word   = shadow_q[slot[2:1]];
    unique case (i_req.addr)
      `ADDR_INT_FLAGS: begin
        rd_mux = flags_view;
      end
      `ADDR_PATH_RESET: begin
        rd_mux[`BIT_TEMP_PATH_RST] = temp_pulse_q;
      end
      `ADDR_USER_CONTROL: begin
        rd_mux = user_view(fifo_enable_q, i2c_pulse_q, fifo_pulse_q, sense_pulse_q);
      end
      default: begin
        if (slot[3]) begin
          rd_mux = slot[0] ? word[15:8] : word[7:0];
        end
      end
    endcase
  end

  // Data is forced to zero between answers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rsp <= '0;
    end else begin
      o_rsp.valid <= rd_strobe;
      o_rsp.rdata <= rd_strobe ? rd_mux : 8'h00;
    end
  end

endmodule : gyro_status_output_control_regs

// ---- tb/gyro_host_model.sv ----
`timescale 1ns/1ps
module gyro_host_model (
  input  wire logic                    i_clk, // clock
  input  wire gyro_regs_pkg::reg_rsp_t i_rsp, // answer
  output gyro_regs_pkg::reg_req_t      o_req  // access
);
  initial o_req = '0;
  // Idle lines show inverted data, so a stale copy never passes
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q,
                      output logic ok);
    ok = w;
    q = 8'h00;
    @(negedge i_clk);
    o_req = {1'b1, w, a, d};
    @(negedge i_clk);
    o_req = {1'b0, w, ~a, ~d};
    for (int i = 0; i < 3 && !ok; i++) begin
      if (i > 0) @(negedge i_clk);
      ok = (i_rsp.valid === 1'b1);
      q = i_rsp.rdata;
    end
  endtask : xfer
endmodule : gyro_host_model

// ---- tb/gyro_regs_sva.sv ----
`timescale 1ns/1ps
module gyro_regs_sva (
  input wire logic                      i_clk,               // clock
  input wire logic                      i_rst,               // reset
  input wire gyro_regs_pkg::reg_req_t   i_req,               // access
  input wire logic                      i_burst_active,      // burst
  input wire gyro_regs_pkg::sample_t    i_sample,            // results
  input wire logic                      i_overflow_event,    // overflow
  input wire logic                      i_drive_ready_event, // drive ready
  input wire logic                      i_read_clear_any,    // read clears
  input wire logic [7:0]                i_irq_enable,        // enables
  input wire gyro_regs_pkg::reg_rsp_t   o_rsp,               // answer
  input wire gyro_regs_pkg::path_ctrl_t o_ctrl,              // controls
  input wire logic                      o_irq                // irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire logic rd_req = i_req.valid && !i_req.write;
  wire logic ctl_wr = i_req.valid && i_req.write && i_req.addr == 8'h6A;
  wire logic tmp_wr = i_req.valid && i_req.write && i_req.addr == 8'h68;
  //////////////////////////////////////////////////////////////////////
  property p_rsp; rd_req |=> o_rsp.valid; endproperty
  a_rsp: assert property (p_rsp) else $error("read not answered");
  property p_wr; !rd_req |=> !o_rsp.valid; endproperty
  a_wr: assert property (p_wr) else $error("answer without read");
  property p_ovf;
    i_overflow_event && i_irq_enable[4] ##1 i_irq_enable[4] [*2] |-> ##1 o_irq;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow irq missing");
  property p_mask; (i_irq_enable == 8'h00)[*2] |=> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("masked irq raised");
  property p_spi; ctl_wr && i_req.wdata[4] |=> o_ctrl.i2c_rst && o_ctrl.spi_only ##1 !o_ctrl.i2c_rst;
  endproperty
  a_spi: assert property (p_spi) else $error("spi lock pulse wrong");
  property p_fifo; ctl_wr && i_req.wdata[2] |=> o_ctrl.fifo_rst ##1 !o_ctrl.fifo_rst; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo reset pulse wrong");
  property p_sense; ctl_wr && i_req.wdata[0] |=> o_ctrl.rate_path_rst && o_ctrl.temp_path_rst;
  endproperty
  a_sense: assert property (p_sense) else $error("path reset missing");
  property p_temp; tmp_wr && i_req.wdata[0] |=> o_ctrl.temp_path_rst && !o_ctrl.rate_path_rst;
  endproperty
  a_temp: assert property (p_temp) else $error("temp reset wrong");
  property p_fen; ctl_wr |=> o_ctrl.fifo_enable == $past(i_req.wdata[6]); endproperty
  a_fen: assert property (p_fen) else $error("fifo enable wrong");
endmodule : gyro_regs_sva
bind gyro_status_output_control_regs gyro_regs_sva u_sva (.i_clk(i_clk), .i_rst(i_rst),
  .i_req(i_req), .i_burst_active(i_burst_active), .i_sample(i_sample),
  .i_overflow_event(i_overflow_event), .i_drive_ready_event(i_drive_ready_event),
  .i_read_clear_any(i_read_clear_any), .i_irq_enable(i_irq_enable), .o_rsp(o_rsp),
  .o_ctrl(o_ctrl), .o_irq(o_irq));

// ---- tb/gyro_status_output_control_regs_bench.sv ----
`timescale 1ns/1ps
module gyro_status_output_control_regs_bench;
  logic                      clk, rst, burst, ovf, drv, rclr, ok, irq;
  logic [7:0]                irq_en, q;
  int                        errors, num_checks;
  gyro_regs_pkg::reg_req_t   req;
  gyro_regs_pkg::reg_rsp_t   rsp;
  gyro_regs_pkg::sample_t    smp;
  gyro_regs_pkg::path_ctrl_t ctrl;
  // Z, Y, X, temperature; X is 1 dps at 131 counts
  logic [63:0]               first_set = 64'h5AA5_FF7D_0083_1234;
  gyro_status_output_control_regs #(.PULSE_CYCLES(1)) u_dut (.i_clk(clk), .i_rst(rst),
    .i_req(req), .i_burst_active(burst), .i_sample(smp), .i_overflow_event(ovf),
    .i_drive_ready_event(drv), .i_read_clear_any(rclr), .i_irq_enable(irq_en),
    .o_rsp(rsp), .o_ctrl(ctrl), .o_irq(irq));
  gyro_host_model u_host (.i_clk(clk), .i_rsp(rsp), .o_req(req));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic rc(input logic [7:0] a, e);
    u_host.xfer(1'b0, a, 8'h00, q, ok);
    if (!ok) begin
      errors++;
      end_sim();
    end else begin
      chk($sformatf("reg %h", a), q, e);
    end
  endtask : rc
  task automatic wr(input logic [7:0] a, d);
    u_host.xfer(1'b1, a, d, q, ok);
  endtask : wr
  task automatic pulse(input logic [64:0] s, input logic o);
    @(negedge clk);
    smp = s;
    ovf = o;
    drv = o;
    @(negedge clk);
    smp.valid = 1'b0;
    ovf = 1'b0;
    drv = 1'b0;
  endtask : pulse
  //////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst, burst, ovf, drv, rclr, irq_en, smp} = {5'h10, 8'h00, 65'h0};
    errors = 0;
    num_checks = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rc(8'h3A, 8'h00);
    rc(8'h6A, 8'h00);
    $display("test reset done");
    irq_en = 8'h10;
    pulse({1'b1, first_set}, 1'b1);
    @(negedge clk);
    chk("irq", {7'h00, irq}, 8'h01);
    rc(8'h3A, 8'h15);
    rc(8'h3A, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    $display("test flags done");
    // Fresh sample lands mid-burst; the burst must still see the old pair
    burst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      rc(8'h41 + i[7:0], first_set[(i / 2) * 16 + (i[0] ? 0 : 8) +: 8]);
      if (i == 0) pulse({1'b1, 64'hFFFF_FFFF_FFFF_FFFF}, 1'b0);
    end
    burst = 1'b0;
    @(negedge clk);
    rc(8'h41, 8'hFF);
    rclr = 1'b1;
    rc(8'h48, 8'hFF);
    rclr = 1'b0;
    rc(8'h3A, 8'h00);
    $display("test results done");
    wr(8'h6A, 8'hF4);
    chk("ctrl", {2'b00, ctrl}, 8'h0F);
    rc(8'h6A, 8'h40);
    chk("spi", {7'h00, ctrl.spi_only}, 8'h01);
    wr(8'h68, 8'hFF);
    chk("ctrl", {2'b00, ctrl}, 8'h23);
    rc(8'h68, 8'h00);
    rc(8'h44, 8'hFF);
    wr(8'h41, 8'h00);
    rc(8'h41, 8'hFF);
    rc(8'h00, 8'h00);
    wr(8'h6A, 8'h01);
    chk("ctrl", {2'b00, ctrl}, 8'h32);
    rc(8'h41, 8'h00);
    rc(8'h6A, 8'h00);
    $display("test control done");
    end_sim();
  end
endmodule : gyro_status_output_control_regs_bench
